/* rtl/plic_pkg.sv */
// Constants and carrier types for the lamp, error tally and interrupt control block
package plic_pkg;
    localparam int          ADDR_W        = 5;
    localparam int          DATA_W        = 16;
    localparam int          NUM_EVT       = 3;
    localparam logic [4:0]  ADDR_LAMP     = 5'h14;
    localparam logic [4:0]  ADDR_TALLY    = 5'h15;
    localparam logic [4:0]  ADDR_ICTRL    = 5'h16;
    localparam logic [4:0]  ADDR_IFLAG    = 5'h17;
    localparam logic [15:0] LAMP_RESET    = 16'h3FE9;
    localparam logic [15:0] TALLY_RESET   = 16'h0000;
    localparam logic [15:0] TALLY_MAX     = 16'hFFFF;
    localparam logic [7:0]  ICTRL_RESET   = 8'h00;
    localparam int          SECOND_LSB    = 3;
    localparam int          FIRST_LSB     = 0;
    localparam int          ICTRL_LSB     = 8;
    localparam int          BIT_OUT_EN    = 15;
    localparam int          BIT_RD_CLR    = 14;
    localparam int          BIT_POLARITY  = 13;
    localparam int          BIT_AUTO_CLR  = 12;
    localparam int          BIT_RESETUP   = 11;
    localparam int          EVT_LSB       = 8;
    localparam logic [2:0]  SRC_LINK      = 3'h0;
    localparam logic [2:0]  SRC_ACT       = 3'h1;
    localparam logic [2:0]  SRC_TX        = 3'h2;
    localparam logic [2:0]  SRC_RX        = 3'h3;
    localparam logic [2:0]  SRC_COL       = 3'h4;
    localparam logic [2:0]  SRC_SPEED     = 3'h5;
    localparam logic [2:0]  SRC_DUPLEX    = 3'h6;
    localparam logic [2:0]  SRC_LAST      = 3'h7;

    // Lamp status sources from the rest of the transceiver
    typedef struct packed {
        logic link_integrity;
        logic activity;
        logic transmit;
        logic receive;
        logic collision;
        logic speed_100;
        logic full_duplex;
        logic link_status;
    } plic_lamp_src_s;

    // Event conditions: bit 2 wake from deep_power_down, bit 1 entry, bit 0 autoneg done
    typedef struct packed {
        logic deep_power_down_wake;
        logic deep_power_down_entry;
        logic an_complete;
    } plic_event_s;
endpackage : plic_pkg

/* rtl/plic_top.sv */
// Status lamp select, receive error tally and interrupt control of the transceiver
`timescale 1ns/100ps
module plic_top (
    input  wire logic                       clk_sys_in,
    input  wire logic                       sys_rst_in,
    input  wire logic                       bank_ext_sel_in,
    input  wire logic [plic_pkg::ADDR_W-1:0] reg_addr_in,
    input  wire logic                       reg_wr_in,
    input  wire logic                       reg_rd_in,
    input  wire logic [plic_pkg::DATA_W-1:0] reg_wdata_in,
    output logic      [plic_pkg::DATA_W-1:0] reg_rdata_out,
    output logic                            reg_rvalid_out,
    input  wire plic_pkg::plic_lamp_src_s   lamp_src_in,
    input  wire logic                       rmii_mode_in,
    input  wire logic                       rx_error_in,
    input  wire plic_pkg::plic_event_s      event_cond_in,
    output logic                            first_status_lamp_out,
    output logic                            second_status_lamp_out,
    output logic                            irq_out,
    output logic                            irq_oe_n_out
);
    logic [15:0] lamp_source_select;
    logic [15:0] receive_error_tally;
    logic [7:0]  interrupt_control;
    logic [plic_pkg::NUM_EVT-1:0] event_flag;
    logic [plic_pkg::NUM_EVT-1:0] cond_prev;
    logic [plic_pkg::NUM_EVT-1:0] cond_now;
    logic [plic_pkg::NUM_EVT-1:0] cond_rise;
    logic [plic_pkg::NUM_EVT-1:0] evt_enable;
    logic [15:0] ictrl_word;
    logic [15:0] flag_word;
    logic        wr_lamp;
    logic        wr_tally;
    logic        wr_ictrl;
    logic        wr_flag;
    logic        rd_flag;
    logic        acc_ok;
    logic        pending;
    logic [15:0] next_rdata;
    // Control fields of the interrupt word
    logic        out_en;
    logic        rd_clr_en;
    logic        irq_active_high;
    logic        auto_clr_en;
    logic        resetup_en;
    logic [plic_pkg::NUM_EVT-1:0] next_event_flag;
    logic        next_irq;

    // Accesses only count while the extended bank is selected
    assign acc_ok   = bank_ext_sel_in;
    assign wr_lamp  = acc_ok && reg_wr_in && (reg_addr_in == plic_pkg::ADDR_LAMP);
    assign wr_tally = acc_ok && reg_wr_in && (reg_addr_in == plic_pkg::ADDR_TALLY);
    assign wr_ictrl = acc_ok && reg_wr_in && (reg_addr_in == plic_pkg::ADDR_ICTRL);
    assign wr_flag  = acc_ok && reg_wr_in && (reg_addr_in == plic_pkg::ADDR_IFLAG);
    assign rd_flag  = acc_ok && reg_rd_in && (reg_addr_in == plic_pkg::ADDR_IFLAG);

    assign cond_now   = event_cond_in;
    assign cond_rise  = cond_now & ~cond_prev;
    assign evt_enable = interrupt_control[plic_pkg::NUM_EVT-1:0];
    assign ictrl_word = {interrupt_control, 8'h00};
    assign flag_word  = {5'h00, event_flag, 8'h00};

    // Control bits by name, so the flag policy below reads like the rules
    assign out_en          = ictrl_word[plic_pkg::BIT_OUT_EN];
    assign rd_clr_en       = ictrl_word[plic_pkg::BIT_RD_CLR];
    assign irq_active_high = ictrl_word[plic_pkg::BIT_POLARITY];
    assign auto_clr_en     = ictrl_word[plic_pkg::BIT_AUTO_CLR];
    assign resetup_en      = ictrl_word[plic_pkg::BIT_RESETUP];

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            lamp_source_select <= plic_pkg::LAMP_RESET;
        end else if (wr_lamp) begin
            lamp_source_select <= reg_wdata_in;
        end
    end

    // Management write wins over a simultaneous error count; count saturates
    // Saturating rather than wrapping, so a flood of errors never reads as few
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            receive_error_tally <= plic_pkg::TALLY_RESET;
        end else if (wr_tally) begin
            receive_error_tally <= reg_wdata_in;
        end else if (rmii_mode_in && rx_error_in &&
                     receive_error_tally != plic_pkg::TALLY_MAX) begin
            receive_error_tally <= receive_error_tally + 16'h0001;
        end
    end

    // Only the upper byte is held here; the lower enables belong to other events
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            interrupt_control <= plic_pkg::ICTRL_RESET;
        end else if (wr_ictrl) begin
            interrupt_control <= reg_wdata_in[15:plic_pkg::ICTRL_LSB];
        end
    end

    // Resets low, the idle level of every condition, so reset alone raises no flag
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            cond_prev <= '0;
        end else begin
            cond_prev <= cond_now;
        end
    end

    // A new condition edge always beats any clear in the same cycle
    always_comb begin
        next_event_flag = event_flag;
        for (int i = 0; i < plic_pkg::NUM_EVT; i++) begin
            if (cond_rise[i]) begin
                next_event_flag[i] = 1'b1;
            end else if (rd_flag && rd_clr_en) begin
                next_event_flag[i] = 1'b0;
            end else if (wr_flag && reg_wdata_in[plic_pkg::EVT_LSB + i] &&
                         !(resetup_en && cond_now[i])) begin
                next_event_flag[i] = 1'b0;
            end else if (auto_clr_en && !cond_now[i]) begin
                next_event_flag[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            event_flag <= '0;
        end else begin
            event_flag <= next_event_flag;
        end
    end

    always_comb begin
        next_rdata = 16'h0000;
        if (acc_ok) begin
            unique case (reg_addr_in)
                plic_pkg::ADDR_LAMP:  next_rdata = lamp_source_select;
                plic_pkg::ADDR_TALLY: next_rdata = receive_error_tally;
                plic_pkg::ADDR_ICTRL: next_rdata = ictrl_word;
                plic_pkg::ADDR_IFLAG: next_rdata = flag_word;
                default:              next_rdata = 16'h0000;
            endcase
        end
    end

    // Read data is captured on the read strobe so a read-clear cannot hide the value
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            reg_rdata_out  <= 16'h0000;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                reg_rdata_out <= next_rdata;
            end
        end
    end

    // Code 7 differs per lamp, so the caller supplies its value
    function automatic logic lamp_pick(input logic [2:0] code,
                                       input plic_pkg::plic_lamp_src_s src,
                                       input logic last_val);
        logic v;
        v = 1'b0;
        unique case (code)
            plic_pkg::SRC_LINK:   v = src.link_integrity;
            plic_pkg::SRC_ACT:    v = src.activity;
            plic_pkg::SRC_TX:     v = src.transmit;
            plic_pkg::SRC_RX:     v = src.receive;
            plic_pkg::SRC_COL:    v = src.collision;
            plic_pkg::SRC_SPEED:  v = src.speed_100;
            plic_pkg::SRC_DUPLEX: v = src.full_duplex;
            plic_pkg::SRC_LAST:   v = last_val;
        endcase
        return v;
    endfunction : lamp_pick

    // Lamps lag source and select by one cycle; pad polarity is set outside
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            first_status_lamp_out  <= 1'b0;
            second_status_lamp_out <= 1'b0;
        end else begin
            first_status_lamp_out  <= lamp_pick(
                lamp_source_select[plic_pkg::FIRST_LSB +: 3],
                lamp_src_in, lamp_src_in.link_status);
            second_status_lamp_out <= lamp_pick(
                lamp_source_select[plic_pkg::SECOND_LSB +: 3],
                lamp_src_in, 1'b0);
        end
    end

    // Flags without an enable still record but never reach the pin
    assign pending  = |(event_flag & evt_enable);
    assign next_irq = irq_active_high ? pending : ~pending;

    // Pin is released while disabled so a wired-or line stays at its idle level
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            irq_out      <= 1'b1;
            irq_oe_n_out <= 1'b1;
        end else begin
            irq_out      <= next_irq;
            irq_oe_n_out <= ~out_en;
        end
    end
endmodule : plic_top

/* test/plic_top_sva.sv */
// Port assertions for the lamp, tally and interrupt block
`timescale 1ns/100ps
module plic_top_sva (
    input wire logic                     clk_sys_in,
    input wire logic                     sys_rst_in,
    input wire logic                     bank_ext_sel_in,
    input wire logic [4:0]               reg_addr_in,
    input wire logic                     reg_wr_in,
    input wire logic                     reg_rd_in,
    input wire logic [15:0]              reg_rdata_out,
    input wire logic                     reg_rvalid_out,
    input wire plic_pkg::plic_lamp_src_s lamp_src_in,
    input wire logic                     first_status_lamp_out,
    input wire logic                     second_status_lamp_out,
    input wire logic                     irq_oe_n_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    property p_rv; reg_rd_in |=> reg_rvalid_out; endproperty
    a_rv: assert property (p_rv) else $error("read not answered");
    property p_nrv; !reg_rd_in |=> !reg_rvalid_out; endproperty
    a_nrv: assert property (p_nrv) else $error("stray read valid");
    property p_hold; !reg_rd_in |=> $stable(reg_rdata_out); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_bank; reg_rd_in && !bank_ext_sel_in |=> reg_rdata_out == 16'h0000; endproperty
    a_bank: assert property (p_bank) else $error("unselected bank read");
    property p_unmap;
        reg_rd_in && !(reg_addr_in inside {[5'h14:5'h17]}) |=> reg_rdata_out == 16'h0000;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_flag;
        reg_rd_in && reg_addr_in == 5'h17 |=> reg_rdata_out[15:11] == 5'h00
            && reg_rdata_out[7:0] == 8'h00;
    endproperty
    a_flag: assert property (p_flag) else $error("flag spare bits");
    // All sources false leaves both lamps dark whatever the select
    property p_dark;
        lamp_src_in == 8'h00 [*2] |=> !first_status_lamp_out && !second_status_lamp_out;
    endproperty
    a_dark: assert property (p_dark) else $error("lamp lit");
    property p_oe; !(reg_wr_in && reg_addr_in == 5'h16) [*3] |=> $stable(irq_oe_n_out); endproperty
    a_oe: assert property (p_oe) else $error("pin enable moved");
endmodule : plic_top_sva
bind plic_top plic_top_sva chk_u (.*);

/* test/plic_sta.sv */
// Management station model driving the register port
`timescale 1ns/100ps
module plic_sta (
    input  wire logic        clk_sys_in,
    input  wire logic [15:0] rdata_in,
    input  wire logic        rvalid_in,
    output logic             bank_out,
    output logic [4:0]       addr_out,
    output logic             wr_out,
    output logic             rd_out,
    output logic [15:0]      wdata_out
);
    initial {bank_out, addr_out, wr_out, rd_out, wdata_out} = {1'b1, 23'h000000};
    // Idle lines show the inverse of the last value so stale data never looks valid
    task automatic put(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_sys_in);
        wr_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask : put
    // Answer is taken while it stands; the call returns on a rising edge
    task automatic get(input logic [4:0] a, output logic [15:0] d, output logic v);
        @(posedge clk_sys_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_sys_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        @(negedge clk_sys_in);
        d = rdata_in;
        v = rvalid_in;
        @(posedge clk_sys_in);
    endtask : get
    task automatic sel(input logic b);
        bank_out <= b;
    endtask : sel
endmodule : plic_sta

/* test/plic_top_tb.sv */
// Self-checking bench for the lamp, tally and interrupt block
`timescale 1ns/100ps
module plic_top_tb;
    logic                     clk = 1'b0;
    logic                     rst = 1'b1;
    logic                     bank, wr, rd, rvalid, lamp0, lamp1, irq, irq_oe_n;
    logic                     rmii = 1'b0;
    logic                     rxe = 1'b0;
    logic [4:0]               addr;
    logic [15:0]              wdata, rdata, got;
    plic_pkg::plic_lamp_src_s src = 8'h00;
    plic_pkg::plic_event_s    evt = 3'h0;
    int                       mismatches = 0;
    int                       num_checks = 0;
    always #50 clk = ~clk;
    plic_sta sta_u (.clk_sys_in(clk), .rdata_in(rdata), .rvalid_in(rvalid),
        .bank_out(bank), .addr_out(addr),
        .wr_out(wr), .rd_out(rd), .wdata_out(wdata));
    plic_top dut_u (.clk_sys_in(clk), .sys_rst_in(rst), .bank_ext_sel_in(bank),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
        .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .lamp_src_in(src),
        .rmii_mode_in(rmii), .rx_error_in(rxe), .event_cond_in(evt),
        .first_status_lamp_out(lamp0), .second_status_lamp_out(lamp1),
        .irq_out(irq), .irq_oe_n_out(irq_oe_n));
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic rchk(input logic [4:0] a, input logic [15:0] e);
        logic v;
        sta_u.get(a, got, v);
        chk(got, e);
        chk({15'h0000, v}, 16'h0001);
    endtask : rchk
    // Expected {irq, irq_oe_n, second lamp, first lamp}, two cycles after the cause
    task automatic pins(input logic [3:0] e);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({12'h000, irq, irq_oe_n, lamp1, lamp0}, {12'h000, e});
        @(posedge clk);
    endtask : pins
    task automatic errs(input logic m, input int n);
        rmii <= m;
        rxe <= 1'b1;
        repeat (n) @(posedge clk);
        rxe <= 1'b0;
        @(posedge clk);
    endtask : errs
    task automatic close_out;
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    initial begin
        #2000000;
        mismatches++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rchk(5'h14, 16'h3FE9);
        rchk(5'h15, 16'h0000);
        rchk(5'h16, 16'h0000);
        rchk(5'h17, 16'h0000);
        rchk(5'h18, 16'h0000);
        pins(4'hC);
        for (int c = 0; c < 8; c++) begin
            sta_u.put(5'h14, {10'h000, c[2:0], c[2:0]});
            src <= 8'h80 >> c;
            pins({2'b11, c != 7, 1'b1});
            src <= ~(8'h80 >> c);
            pins(4'hC);
        end
        src <= 8'h00;
        sta_u.sel(1'b0);
        sta_u.put(5'h14, 16'h1234);
        rchk(5'h14, 16'h0000);
        sta_u.sel(1'b1);
        rchk(5'h14, 16'h003F);
        errs(1'b1, 5);
        errs(1'b0, 3);
        rchk(5'h15, 16'h0005);
        sta_u.put(5'h15, 16'hFFFE);
        errs(1'b1, 3);
        rchk(5'h15, 16'hFFFF);
        sta_u.put(5'h16, 16'h8100);
        evt <= 3'b001;
        pins(4'h0);
        rchk(5'h17, 16'h0100);
        evt <= 3'b000;
        rchk(5'h17, 16'h0100);
        sta_u.put(5'h17, 16'h0100);
        pins(4'h8);
        evt <= 3'b110;
        pins(4'h8);
        rchk(5'h17, 16'h0600);
        sta_u.put(5'h16, 16'hFF00);
        pins(4'h8);
        sta_u.put(5'h17, 16'h0600);
        rchk(5'h17, 16'h0600);
        rchk(5'h17, 16'h0000);
        pins(4'h0);
        evt <= 3'b111;
        @(posedge clk);
        evt <= 3'b110;
        rchk(5'h17, 16'h0000);
        close_out();
    end
endmodule : plic_top_tb
